//--- common/thermal_alert_pkg.sv
// constants shared by the thermal limit and alert control block
package thermal_alert_pkg;
  // ==================================================
  // register pointers
  localparam logic [7:0] ptr_capability = 8'h00;
  localparam logic [7:0] ptr_config = 8'h01;
  localparam logic [7:0] ptr_high = 8'h02;
  localparam logic [7:0] ptr_low = 8'h03;
  localparam logic [7:0] ptr_crit = 8'h04;
  localparam logic [7:0] ptr_temp = 8'h05;
  localparam logic [7:0] ptr_maker = 8'h06;
  localparam logic [7:0] ptr_device = 8'h07;
  localparam logic [7:0] ptr_resolution = 8'h08;
  // ==================================================
  // configuration field positions
  localparam int hyst_hi_bit = 10;
  localparam int hyst_lo_bit = 9;
  localparam int power_down_pos = 8;
  localparam int crit_freeze_pos = 7;
  localparam int window_freeze_pos = 6;
  localparam int alert_clear_pos = 5;
  localparam int asserted_flag_pos = 4;
  localparam int alert_enable_pos = 3;
  localparam int crit_only_pos = 2;
  localparam int polarity_pos = 1;
  localparam int mode_pos = 0;
  // resolution field position in capability and resolution registers
  localparam int res_hi_bit = 4;
  localparam int res_lo_bit = 3;
  // ==================================================
  // reset values and fixed read patterns
  localparam logic [1:0] hyst_reset = 2'h0;
  localparam logic [1:0] res_reset = 2'h1;
  localparam logic [15:0] capability_base = 16'h0067;
  localparam logic [15:0] resolution_base = 16'h0007;
  localparam logic [10:0] limit_reset = 11'h000;
  // ==================================================
  // hysteresis in quarter-degree steps: 0, 1.5, 3, 6 degrees
  localparam logic [11:0] hyst_off = 12'h000;
  localparam logic [11:0] hyst_small = 12'h006;
  localparam logic [11:0] hyst_mid = 12'h00c;
  localparam logic [11:0] hyst_big = 12'h018;
  // ==================================================
  // data masks per resolution code on temperature bits 12:0
  localparam logic [12:0] mask_half = 13'h1ff8;
  localparam logic [12:0] mask_quarter = 13'h1ffc;
  localparam logic [12:0] mask_eighth = 13'h1ffe;
  localparam logic [12:0] mask_sixteenth = 13'h1fff;
endpackage

//--- logic/thermal_limit_alert_control.sv
// limit comparison, configuration and alert pin logic of the temperature sensor
`timescale 1ns/1ps
// What this block does
// R1: high flag sets above upper limit, clears at limit minus hysteresis; low sets below limit minus hysteresis, clears at limit.
// R2: hysteresis field picks 0, 1.5, 3 or 6 degrees for all limits.
// R3: power-down bit stops sampling, alert updates and temperature data updates.
// R4: locks stop setting power-down; clearing it always works.
// R5: register access keeps working during power-down.
// R6: critical limit freeze ignores writes to the critical limit.
// R7: window freeze ignores writes to the high and low limits.
// R8: lock bits are set-only; only power-on reset clears them.
// R9: alert clear is write-only, self-clearing, reads zero; writing zero does nothing.
// R10: in interrupt mode alert clear releases the pin until a new event.
// R11: in comparator mode alert clear is ignored.
// R12: asserted flag reads one exactly while the pin is driven active.
// R13: alert enable gates the pin; unwritable while any lock is set.
// R14: critical-only limits alert to critical; unwritable under window freeze.
// R15: polarity bit selects the active level of the alert pin.
// R16: mode bit selects comparator or latched interrupt behaviour.
// R17: limits and temperature are two's complement, bits 12 to 2 always defined.
// R18: comparisons use only temperature bits 12 to 2.
// R19: finer resolutions show all their bits in temperature data reads only.
// R20: host writes zero to limit bit 2 at half-degree resolution.
// R21: host writes zero to unused limit bits.
// R22: hysteresis field is unwritable while any lock is set.
// R23: resolution field selects 0.5 to 0.0625 degree steps, resets to 0.25.
// R24: comparisons and alert re-evaluate only when a new sample completes.
module thermal_limit_alert_control #(
  parameter logic [15:0] maker_code = 16'h1234,   // arbitrary value
  parameter logic [15:0] device_code = 16'h5678   // arbitrary value
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_ptr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic sample_valid_i,
  input wire logic [12:0] sample_temp_i,
  output logic sensing_on_o,
  output logic alert_o,
  output logic alert_oe_o
);
  // ==================================================
  // configuration state
  logic power_down_bit_ff;
  logic critical_limit_freeze_ff;
  logic window_freeze_ff;
  logic alert_enable_ff;
  logic critical_only_select_ff;
  logic alert_polarity_ff;
  logic alert_mode_ff;
  logic [1:0] hyst_sel_ff;
  logic [1:0] resolution_select_ff;
  logic [10:0] high_limit_ff;
  logic [10:0] low_limit_ff;
  logic [10:0] critical_limit_ff;
  logic [12:0] temp_data_ff;
  logic above_ff;
  logic below_ff;
  logic crit_ff;
  logic cond_ff;
  logic latch_ff;
  logic alert_asserted_flag_ff;
  logic any_lock;
  logic wr_cfg;
  logic clear_req;
  logic take_sample;
  logic signed [11:0] temp_cmp;
  logic signed [11:0] hyst_val;
  logic signed [11:0] hi_lim;
  logic signed [11:0] lo_lim;
  logic signed [11:0] cr_lim;
  logic nxt_above;
  logic nxt_below;
  logic nxt_crit;
  logic nxt_cond;
  logic [12:0] res_mask;
  logic nxt_asserted;

  assign any_lock = critical_limit_freeze_ff | window_freeze_ff;
  assign wr_cfg = reg_wr_i & (reg_ptr_i == thermal_alert_pkg::ptr_config);
  // R9: clear acts only on a one
  assign clear_req = wr_cfg & reg_wdata_i[thermal_alert_pkg::alert_clear_pos];
  // R3: no sample taken while powered down
  assign take_sample = sample_valid_i & ~power_down_bit_ff;

  // ==================================================
  // configuration register writes
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      power_down_bit_ff <= 1'b0;
      critical_limit_freeze_ff <= 1'b0;
      window_freeze_ff <= 1'b0;
      alert_enable_ff <= 1'b0;
      critical_only_select_ff <= 1'b0;
      alert_polarity_ff <= 1'b0;
      alert_mode_ff <= 1'b0;
      hyst_sel_ff <= thermal_alert_pkg::hyst_reset;
    end
    else if (wr_cfg)
    begin
      // R4: set blocked by locks, clear always allowed
      if (!reg_wdata_i[thermal_alert_pkg::power_down_pos])
        power_down_bit_ff <= 1'b0;
      else if (!any_lock)
        power_down_bit_ff <= 1'b1;
      // R8: lock bits only ever set by a write
      critical_limit_freeze_ff <= critical_limit_freeze_ff | reg_wdata_i[thermal_alert_pkg::crit_freeze_pos];
      window_freeze_ff <= window_freeze_ff | reg_wdata_i[thermal_alert_pkg::window_freeze_pos];
      // R13: enable frozen by either lock
      if (!any_lock)
        alert_enable_ff <= reg_wdata_i[thermal_alert_pkg::alert_enable_pos];
      // R22: hysteresis frozen by either lock
      if (!any_lock)
        hyst_sel_ff <= reg_wdata_i[thermal_alert_pkg::hyst_hi_bit:thermal_alert_pkg::hyst_lo_bit];
      // R14: critical-only frozen by window lock
      if (!window_freeze_ff)
        critical_only_select_ff <= reg_wdata_i[thermal_alert_pkg::crit_only_pos];
      // R15: polarity freely writable
      alert_polarity_ff <= reg_wdata_i[thermal_alert_pkg::polarity_pos];
      // R16: mode freely writable
      alert_mode_ff <= reg_wdata_i[thermal_alert_pkg::mode_pos];
    end
  end

  // ==================================================
  // resolution and limit registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      resolution_select_ff <= thermal_alert_pkg::res_reset;
      high_limit_ff <= thermal_alert_pkg::limit_reset;
      low_limit_ff <= thermal_alert_pkg::limit_reset;
      critical_limit_ff <= thermal_alert_pkg::limit_reset;
    end
    else if (reg_wr_i)
    begin
      // R23: resolution code stored from its field
      if (reg_ptr_i == thermal_alert_pkg::ptr_resolution)
        resolution_select_ff <= reg_wdata_i[thermal_alert_pkg::res_hi_bit:thermal_alert_pkg::res_lo_bit];
      // R7: window limits ignore writes under window lock
      if (reg_ptr_i == thermal_alert_pkg::ptr_high && !window_freeze_ff)
        high_limit_ff <= reg_wdata_i[12:2];
      if (reg_ptr_i == thermal_alert_pkg::ptr_low && !window_freeze_ff)
        low_limit_ff <= reg_wdata_i[12:2];
      // R6: critical limit ignores writes under its lock
      if (reg_ptr_i == thermal_alert_pkg::ptr_crit && !critical_limit_freeze_ff)
        critical_limit_ff <= reg_wdata_i[12:2];
    end
  end

  // ==================================================
  // comparison arithmetic
  always_comb
  begin
    // R2: hysteresis decode in quarter degrees
    case (hyst_sel_ff)
      2'h1: hyst_val = thermal_alert_pkg::hyst_small;
      2'h2: hyst_val = thermal_alert_pkg::hyst_mid;
      2'h3: hyst_val = thermal_alert_pkg::hyst_big;
      default: hyst_val = thermal_alert_pkg::hyst_off;
    endcase
  end

  // R18: only bits 12 to 2, sign-extended for headroom under hysteresis
  // R17: all operands two's complement
  assign temp_cmp = {sample_temp_i[12], sample_temp_i[12:2]};
  assign hi_lim = {high_limit_ff[10], high_limit_ff};
  assign lo_lim = {low_limit_ff[10], low_limit_ff};
  assign cr_lim = {critical_limit_ff[10], critical_limit_ff};

  always_comb
  begin
    // R1: set above high limit, hold until at or below limit minus hysteresis
    nxt_above = above_ff ? (temp_cmp > (hi_lim - hyst_val)) : (temp_cmp > hi_lim);
    // R1: set below low limit minus hysteresis, hold until reaching low limit
    nxt_below = below_ff ? (temp_cmp < lo_lim) : (temp_cmp < (lo_lim - hyst_val));
    nxt_crit = crit_ff ? (temp_cmp > (cr_lim - hyst_val)) : (temp_cmp > cr_lim);
    // R14: window conditions drop out in critical-only mode
    nxt_cond = nxt_crit | (~critical_only_select_ff & (nxt_above | nxt_below));
  end

  always_comb
  begin
    // R19: data keeps as many low bits as the resolution provides
    case (resolution_select_ff)
      2'h0: res_mask = thermal_alert_pkg::mask_half;
      2'h1: res_mask = thermal_alert_pkg::mask_quarter;
      2'h2: res_mask = thermal_alert_pkg::mask_eighth;
      default: res_mask = thermal_alert_pkg::mask_sixteenth;
    endcase
  end

  // ==================================================
  // sample-driven status
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      above_ff <= 1'b0;
      below_ff <= 1'b0;
      crit_ff <= 1'b0;
      cond_ff <= 1'b0;
      temp_data_ff <= 13'h0000;
    end
    // R24: status moves only on a completed sample
    else if (take_sample)
    begin
      above_ff <= nxt_above;
      below_ff <= nxt_below;
      crit_ff <= nxt_crit;
      cond_ff <= nxt_cond;
      temp_data_ff <= sample_temp_i & res_mask;
    end
  end

  // interrupt latch: a new condition on a sample wins over a same-cycle clear
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      latch_ff <= 1'b0;
    // R10: new event sets the latch
    else if (take_sample && nxt_cond && !cond_ff)
      latch_ff <= 1'b1;
    // R10: clear releases only in interrupt mode
    // R11: comparator mode leaves the latch alone
    else if (clear_req && alert_mode_ff)
      latch_ff <= 1'b0;
  end

  // R16: comparator follows the condition, interrupt follows the latch
  // R13: enable gates the pin
  assign nxt_asserted = alert_enable_ff & (alert_mode_ff ? latch_ff : cond_ff);

  // ==================================================
  // alert pin, open drain: the pad is driven only when the level is zero
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      alert_asserted_flag_ff <= 1'b0;
      alert_o <= 1'b1;
      alert_oe_o <= 1'b0;
      sensing_on_o <= 1'b0;
    end
    else
    begin
      // R12: flag tracks the driven-active state
      alert_asserted_flag_ff <= nxt_asserted;
      // R15: active level comes from polarity
      alert_o <= nxt_asserted ~^ alert_polarity_ff;
      alert_oe_o <= ~(nxt_asserted ~^ alert_polarity_ff);
      // R3: converter runs only out of power-down
      sensing_on_o <= ~power_down_bit_ff;
    end
  end

  // ==================================================
  // register reads; they keep answering in power-down
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      // R5: reads are never gated by power-down
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        case (reg_ptr_i)
          thermal_alert_pkg::ptr_capability:
            reg_rdata_o <= thermal_alert_pkg::capability_base | {11'h000, resolution_select_ff, 3'h0};
          // R9: clear bit always reads zero
          thermal_alert_pkg::ptr_config:
            reg_rdata_o <= {5'h00, hyst_sel_ff, power_down_bit_ff, critical_limit_freeze_ff, window_freeze_ff,
                            1'b0, alert_asserted_flag_ff, alert_enable_ff, critical_only_select_ff,
                            alert_polarity_ff, alert_mode_ff};
          thermal_alert_pkg::ptr_high: reg_rdata_o <= {3'h0, high_limit_ff, 2'h0};
          thermal_alert_pkg::ptr_low: reg_rdata_o <= {3'h0, low_limit_ff, 2'h0};
          thermal_alert_pkg::ptr_crit: reg_rdata_o <= {3'h0, critical_limit_ff, 2'h0};
          thermal_alert_pkg::ptr_temp: reg_rdata_o <= {crit_ff, above_ff, below_ff, temp_data_ff};
          thermal_alert_pkg::ptr_maker: reg_rdata_o <= maker_code;
          thermal_alert_pkg::ptr_device: reg_rdata_o <= device_code;
          thermal_alert_pkg::ptr_resolution:
            reg_rdata_o <= thermal_alert_pkg::resolution_base | {11'h000, resolution_select_ff, 3'h0};
          default: reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // ==================================================
  // checks
  sequence cfg_write_one(int pos);
    wr_cfg && reg_wdata_i[pos];
  endsequence

  chk_lock_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R8
    critical_limit_freeze_ff |=> critical_limit_freeze_ff)
    else $error("critical freeze dropped");
  chk_window_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R8
    window_freeze_ff |=> window_freeze_ff)
    else $error("window freeze dropped");
  chk_pd_lock_block: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R4
    (any_lock && !power_down_bit_ff) |=> !power_down_bit_ff)
    else $error("power-down set under lock");
  chk_crit_lock_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R6
    critical_limit_freeze_ff |=> $stable(critical_limit_ff))
    else $error("critical limit changed under lock");
  chk_window_lock_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R7
    window_freeze_ff |=> ($stable(high_limit_ff) && $stable(low_limit_ff)))
    else $error("window limit changed under lock");
  chk_enable_lock_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
    any_lock |=> ($stable(alert_enable_ff) && $stable(hyst_sel_ff)))
    else $error("enable or hysteresis changed under lock");
  chk_pd_no_update: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R3
    power_down_bit_ff |=> ($stable(temp_data_ff) && $stable(cond_ff)))
    else $error("status moved in power-down");
  chk_flag_pin_match: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R12
    alert_asserted_flag_ff == (alert_o == alert_polarity_ff ^ $past(alert_polarity_ff) ^ alert_polarity_ff))
    else $error("flag disagrees with pin");
  chk_clear_release: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R10
    (cfg_write_one(thermal_alert_pkg::alert_clear_pos) ##0 alert_mode_ff && !take_sample) |=> ##1 !alert_asserted_flag_ff)
    else $error("alert clear did not release pin");
  chk_comparator_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R16
    (!alert_mode_ff && alert_enable_ff && $stable(alert_mode_ff) && $stable(alert_enable_ff))
      |=> alert_asserted_flag_ff == $past(cond_ff))
    else $error("comparator mode not following condition");
  chk_sample_only: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R24
    !take_sample |=> ($stable(above_ff) && $stable(below_ff) && $stable(crit_ff)))
    else $error("status changed between samples");
  chk_read_answer: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R5
    reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
endmodule

//--- sim/reg_host_model.sv
// register bus host model that drives the thermal alert block
`timescale 1ns/1ps
module reg_host_model (
  input wire logic clk_i,
  output logic [7:0] ptr_o,
  output logic wr_o,
  output logic [15:0] wdata_o,
  output logic rd_o,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i
);
  // ====================
  // idle bus
  // released lines carry inverted values, never a stale copy
  initial
  begin
    ptr_o = 8'hff;
    wr_o = 1'b0;
    wdata_o = 16'hffff;
    rd_o = 1'b0;
  end
  // ====================
  // bus cycles
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    ptr_o = p;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    ptr_o = ~p;
    wdata_o = ~d;
  endtask
  task automatic wl(input logic [7:0] p, input logic [10:0] q);
    wr(p, {3'h0, q, 2'h0});
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    @(posedge clk_i);
    #1;
    ptr_o = p;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    ptr_o = ~p;
    d = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
  endtask
endmodule

//--- sim/thermal_limit_alert_control_tb.sv
// self-checking bench for the thermal limit and alert block
`timescale 1ns/1ps
module thermal_limit_alert_control_tb;
  logic clk, reset_n, wr, rd, rvalid, svalid, sense_on, alert, alert_oe;
  logic [7:0] ptr;
  logic [15:0] wdata, rdata;
  logic [12:0] stemp;
  int fails = 0;
  int check_count = 0;
  // ====================
  // design and host
  // identity values are arbitrary; overriding them makes the expected reads independent of the defaults
  localparam logic [15:0] maker_val = 16'h0a5c;
  localparam logic [15:0] device_val = 16'h3c96;
  thermal_limit_alert_control #(.maker_code(maker_val), .device_code(device_val)) i_thermal_limit_alert_control (
    .clk_i(clk), .reset_n_i(reset_n), .reg_ptr_i(ptr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sample_valid_i(svalid),
    .sample_temp_i(stemp), .sensing_on_o(sense_on), .alert_o(alert), .alert_oe_o(alert_oe));
  reg_host_model i_reg_host_model (
    .clk_i(clk), .ptr_o(ptr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ====================
  // helpers
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic w(input logic [7:0] p, input logic [15:0] d);
    i_reg_host_model.wr(p, d);
  endtask
  task automatic rchk(input string n, input logic [7:0] p, input logic [15:0] e);
    logic [15:0] v;
    i_reg_host_model.rd(p, v);
    check(n, v, e);
  endtask
  // converter pulse; the temperature lines show inverted data once released
  task automatic smp(input logic [12:0] t);
    @(posedge clk);
    #1;
    stemp = t;
    svalid = 1'b1;
    @(posedge clk);
    #1;
    svalid = 1'b0;
    stemp = ~t;
  endtask
  // pin and flag settle two cycles after their cause
  task automatic pin(input logic a, input logic p);
    logic [15:0] v;
    repeat (2) @(posedge clk);
    #1;
    check("alert_o", {15'h0, alert}, {15'h0, a ~^ p});
    check("alert_oe_o", {15'h0, alert_oe}, {15'h0, a ^ p});
    i_reg_host_model.rd(8'h01, v);
    check("asserted_flag", {15'h0, v[4]}, {15'h0, a});
  endtask
  // ====================
  // scenarios
  task automatic t_reset();
    rchk("config", 8'h01, 16'h0000);
    rchk("resolution", 8'h08, 16'h000f);
    rchk("capability", 8'h00, 16'h006f);
    rchk("unmapped", 8'h09, 16'h0000);
    rchk("maker", 8'h06, maker_val);
    rchk("device", 8'h07, device_val);
    check("sensing_on_o", {15'h0, sense_on}, 16'h0001);
    pin(1'b0, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_hyst();
    int hq[4] = '{0, 6, 12, 24};
    // limits kept even for half-degree steps
    i_reg_host_model.wl(8'h04, 11'h190);
    i_reg_host_model.wl(8'h02, 11'h0a0);
    for (int h = 0; h < 4; h++)
    begin
      w(8'h01, {5'h0, 2'(h), 9'h008});
      smp(13'h284);
      pin(1'b1, 1'b0);
      rchk("temp", 8'h05, 16'h4284);
      w(8'h01, {5'h0, 2'(h), 9'h028});
      pin(1'b1, 1'b0);
      rchk("config", 8'h01, {5'h0, 2'(h), 9'h018});
      smp(13'((161 - hq[h]) * 4));
      pin(1'b1, 1'b0);
      smp(13'((160 - hq[h]) * 4));
      pin(1'b0, 1'b0);
    end
    $display("test hysteresis done");
  endtask
  task automatic t_low();
    w(8'h01, 16'h0208);
    i_reg_host_model.wl(8'h03, 11'h028);
    smp(13'h090);
    pin(1'b0, 1'b0);
    smp(13'h084);
    pin(1'b1, 1'b0);
    rchk("temp", 8'h05, 16'h2084);
    smp(13'h09c);
    pin(1'b1, 1'b0);
    smp(13'h0a0);
    pin(1'b0, 1'b0);
    $display("test low done");
  endtask
  task automatic t_intr();
    w(8'h01, 16'h000b);
    smp(13'h2a8);
    pin(1'b1, 1'b1);
    w(8'h01, 16'h002b);
    pin(1'b0, 1'b1);
    smp(13'h2a8);
    pin(1'b0, 1'b1);
    smp(13'h190);
    smp(13'h2a8);
    pin(1'b1, 1'b1);
    w(8'h01, 16'h0003);
    pin(1'b0, 1'b1);
    w(8'h01, 16'h000b);
    pin(1'b1, 1'b1);
    $display("test interrupt done");
  endtask
  task automatic t_crit();
    w(8'h01, 16'h000c);
    smp(13'h2a8);
    pin(1'b0, 1'b0);
    smp(13'h644);
    pin(1'b1, 1'b0);
    rchk("temp", 8'h05, 16'hc644);
    w(8'h01, 16'h0008);
    smp(13'h2a8);
    pin(1'b1, 1'b0);
    $display("test critical done");
  endtask
  task automatic t_power();
    w(8'h01, 16'h0108);
    pin(1'b1, 1'b0);
    check("sensing_on_o", {15'h0, sense_on}, 16'h0000);
    smp(13'h190);
    rchk("temp", 8'h05, 16'h42a8);
    pin(1'b1, 1'b0);
    w(8'h01, 16'h0008);
    pin(1'b1, 1'b0);
    check("sensing_on_o", {15'h0, sense_on}, 16'h0001);
    $display("test power down done");
  endtask
  task automatic t_res();
    w(8'h08, 16'h0018);
    rchk("resolution", 8'h08, 16'h001f);
    rchk("capability", 8'h00, 16'h007f);
    smp(13'h283);
    pin(1'b0, 1'b0);
    rchk("temp", 8'h05, 16'h0283);
    w(8'h08, 16'h0000);
    smp(13'h287);
    pin(1'b1, 1'b0);
    rchk("temp", 8'h05, 16'h4280);
    w(8'h08, 16'h0010);
    rchk("resolution", 8'h08, 16'h0017);
    smp(13'h287);
    rchk("temp", 8'h05, 16'h4286);
    $display("test resolution done");
  endtask
  task automatic t_lock();
    w(8'h01, 16'h0100);
    w(8'h01, 16'h0180);
    rchk("config", 8'h01, 16'h0180);
    w(8'h01, 16'h0080);
    rchk("config", 8'h01, 16'h0080);
    i_reg_host_model.wl(8'h04, 11'h040);
    rchk("crit", 8'h04, 16'h0640);
    i_reg_host_model.wl(8'h02, 11'h0c0);
    rchk("high", 8'h02, 16'h0300);
    w(8'h01, 16'h070f);
    rchk("config", 8'h01, 16'h0087);
    w(8'h01, 16'h0047);
    i_reg_host_model.wl(8'h02, 11'h100);
    rchk("high", 8'h02, 16'h0300);
    w(8'h01, 16'h0000);
    rchk("config", 8'h01, 16'h00c4);
    @(posedge clk);
    #1;
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    rchk("config", 8'h01, 16'h0000);
    i_reg_host_model.wl(8'h04, 11'h040);
    rchk("crit", 8'h04, 16'h0100);
    $display("test lock done");
  endtask
  // ====================
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    svalid = 1'b0;
    stemp = 13'h0000;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_hyst();
    t_low();
    t_intr();
    t_crit();
    t_power();
    t_res();
    t_lock();
    summarize();
  end
  // the scenarios need well under two thousand cycles
  initial
  begin
    #100000;
    fails++;
    summarize();
  end
endmodule
